// ### hw/spcr_pkg.sv
// spcr_pkg: register map, field positions, reset values and spi framing
// for the lane phy and clock recovery control register bank.
// assumes a 16-bit spi instruction (read flag + 15-bit address) then 8 data bits.
package spcr_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;

  // register byte addresses on the serial port
  localparam logic [14:0] ADDR_LANE_PD = 15'h0201;
  localparam logic [14:0] ADDR_MISC_PD = 15'h0203;
  localparam logic [14:0] ADDR_RECOV_RST = 15'h0206;
  localparam logic [14:0] ADDR_RECOV_MODE = 15'h0230;
  localparam logic [14:0] ADDR_EQ_LANE01 = 15'h0250;

  // reset values of whole bytes
  localparam logic [7:0] RST_LANE_PD = 8'h00;
  localparam logic [7:0] RST_MISC_PD = 8'h00;
  localparam logic [7:0] RST_RECOV_RST = 8'h01;
  localparam logic [7:0] RST_RECOV_MODE = 8'h60;
  localparam logic [7:0] RST_EQ_LANE01 = 8'h88;

  // field positions
  localparam int SYNC_PD_BIT = 1;
  localparam int RUN_BIT = 0;
  localparam int HALF_RATE_BIT = 5;
  localparam int DIV_LSB = 1;
  localparam int EQ_LANE0_LSB = 0;
  localparam int EQ_LANE1_LSB = 4;

  // oversampling divider codes
  localparam logic [1:0] DIV_NONE = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;

  // equalizer code selecting manual mode
  localparam logic [3:0] EQ_MANUAL = 4'h0;

  // read value of unmapped addresses
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // instruction word bit that marks a read
  localparam int RD_FLAG_BIT = 15;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h07;

  typedef enum logic [3:0] {
    SPCR_IDLE = 4'h1,
    SPCR_INSTR = 4'h2,
    SPCR_DATA = 4'h4,
    SPCR_DONE = 4'h8
  } spcr_state_e;

endpackage : spcr_pkg

// ### hw/spcr_regs.sv
// spcr_regs: serial-port register bank driving lane phy power down, the
// sync-request buffer power down, clock recovery reset/rate/divider and the
// lane 0/1 equalizer boost settings.
// assumes spi mode 0, msb first, sclk at most clk/8; all pins are async.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - lane power-down bits 3 to 7 each power down their own lane phy.
// - lane power-down bits 0 to 2 power down lanes 0, 1 and 2.
// - misc power-down bit 1 set powers down the sync-request buffer.
// - recovery reset bit 0 low holds recovery logic in reset; resets high.
// - half-rate bit selects half-rate recovery when set; resets to one.
// - divider field 00 none, 01 divide by two, 10 divide by four.
// - equalizer code 0000 is manual mode, other codes give that boost.
module spcr_regs
  import spcr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic [7:0] lane_phy_powerdown,
  output logic sync_request_buffer_powerdown,
  output logic recovery_logic_run,
  output logic half_rate_enable,
  output logic [1:0] oversample_div,
  output logic div_by1,
  output logic div_by2,
  output logic div_by4,
  output logic [3:0] lane0_equalizer_setting,
  output logic [3:0] lane1_equalizer_setting,
  output logic lane0_eq_manual,
  output logic lane1_eq_manual
);

  function automatic logic eq_is_manual(input logic [3:0] code);
    eq_is_manual = (code == EQ_MANUAL);
  endfunction : eq_is_manual

  // pin synchronisers; the second stage is looked at, plus a third sclk stage for edge detection
  logic cs_meta_q, cs_s_q, sclk_meta_q, sclk_s_q, sclk_prev_q;
  logic sdi_meta_q, sdi_s_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta_q <= 1'b1;
      cs_s_q <= 1'b1;
      sclk_meta_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      sdi_meta_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end else begin
      cs_meta_q <= spi_cs_n;
      cs_s_q <= cs_meta_q;
      sclk_meta_q <= spi_sclk;
      sclk_s_q <= sclk_meta_q;
      sclk_prev_q <= sclk_s_q;
      sdi_meta_q <= spi_sdi;
      sdi_s_q <= sdi_meta_q;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s_q & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s_q & sclk_prev_q;

  // register storage; reserved bits are not stored at all
  logic [7:0] lane_pd_q, lane_pd_d;
  logic sync_pd_q, sync_pd_d, run_q, run_d, half_q, half_d;
  logic [1:0] div_q, div_d;
  logic [3:0] eq0_q, eq0_d, eq1_q, eq1_d;

  // serial framing
  spcr_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [14:0] instr_q, instr_d, addr_q, addr_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d, sdo_q, sdo_d, oe_q, oe_d, wr_en;
  logic [7:0] wr_data;

  // reserved fields read back their reset values
  function automatic logic [7:0] read_mux(input logic [14:0] a,
      input logic [7:0] lpd, input logic spd, input logic run,
      input logic half, input logic [1:0] div, input logic [3:0] e0,
      input logic [3:0] e1);
    logic [7:0] v;
    v = RD_UNMAPPED;
    case (a)
      ADDR_LANE_PD: v = lpd;
      ADDR_MISC_PD: begin
        v = RST_MISC_PD;
        v[SYNC_PD_BIT] = spd;
      end
      ADDR_RECOV_RST: begin
        v = RST_RECOV_RST;
        v[RUN_BIT] = run;
      end
      ADDR_RECOV_MODE: begin
        v = RST_RECOV_MODE;
        v[HALF_RATE_BIT] = half;
        v[DIV_LSB +: 2] = div;
      end
      ADDR_EQ_LANE01: v = {e1, e0};
      default: v = RD_UNMAPPED;
    endcase
    read_mux = v;
  endfunction : read_mux

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    instr_d = instr_q;
    addr_d = addr_q;
    rd_d = rd_q;
    sh_d = sh_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    wr_data = {sh_q[6:0], sdi_s_q};
    if (cs_s_q) begin
      // deselect aborts any frame; a partial write byte is dropped
      state_d = SPCR_IDLE;
      oe_d = 1'b0;
      sdo_d = 1'b0;
    end else begin
      case (state_q)
        SPCR_IDLE: begin
          state_d = SPCR_INSTR;
          cnt_d = 5'h00;
        end
        SPCR_INSTR: begin
          if (sclk_rise) begin
            instr_d = {instr_q[13:0], sdi_s_q};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == INSTR_LAST) begin
              addr_d = {instr_q[13:0], sdi_s_q};
              rd_d = instr_q[RD_FLAG_BIT - 1];
              sh_d = read_mux({instr_q[13:0], sdi_s_q}, lane_pd_q, sync_pd_q,
                              run_q, half_q, div_q, eq0_q, eq1_q);
              cnt_d = 5'h00;
              state_d = SPCR_DATA;
            end
          end
        end
        SPCR_DATA: begin
          if (rd_q) begin
            oe_d = 1'b1;
            if (sclk_fall) begin
              sdo_d = sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
            end
            if (sclk_rise) begin
              cnt_d = cnt_q + 5'h01;
              if (cnt_q == DATA_LAST) begin
                state_d = SPCR_DONE;
              end
            end
          end else if (sclk_rise) begin
            sh_d = {sh_q[6:0], sdi_s_q};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == DATA_LAST) begin
              wr_en = 1'b1;
              state_d = SPCR_DONE;
            end
          end
        end
        SPCR_DONE: begin
          // extra clocks are ignored until deselect
          if (sclk_fall) begin
            oe_d = 1'b0;
          end
        end
        default: state_d = SPCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SPCR_IDLE;
      cnt_q <= 5'h00;
      instr_q <= 15'h0000;
      addr_q <= 15'h0000;
      rd_q <= 1'b0;
      sh_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      instr_q <= instr_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      sh_q <= sh_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  always_comb begin
    lane_pd_d = lane_pd_q;
    sync_pd_d = sync_pd_q;
    run_d = run_q;
    half_d = half_q;
    div_d = div_q;
    eq0_d = eq0_q;
    eq1_d = eq1_q;
    if (wr_en) begin
      case (addr_q)
        ADDR_LANE_PD: lane_pd_d = wr_data;
        ADDR_MISC_PD: sync_pd_d = wr_data[SYNC_PD_BIT];
        ADDR_RECOV_RST: run_d = wr_data[RUN_BIT];
        ADDR_RECOV_MODE: begin
          half_d = wr_data[HALF_RATE_BIT];
          div_d = wr_data[DIV_LSB +: 2];
        end
        ADDR_EQ_LANE01: begin
          eq0_d = wr_data[EQ_LANE0_LSB +: 4];
          eq1_d = wr_data[EQ_LANE1_LSB +: 4];
        end
        default: lane_pd_d = lane_pd_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_pd_q <= RST_LANE_PD;
      sync_pd_q <= RST_MISC_PD[SYNC_PD_BIT];
      run_q <= RST_RECOV_RST[RUN_BIT];
      half_q <= RST_RECOV_MODE[HALF_RATE_BIT];
      div_q <= RST_RECOV_MODE[DIV_LSB +: 2];
      eq0_q <= RST_EQ_LANE01[EQ_LANE0_LSB +: 4];
      eq1_q <= RST_EQ_LANE01[EQ_LANE1_LSB +: 4];
    end else begin
      lane_pd_q <= lane_pd_d;
      sync_pd_q <= sync_pd_d;
      run_q <= run_d;
      half_q <= half_d;
      div_q <= div_d;
      eq0_q <= eq0_d;
      eq1_q <= eq1_d;
    end
  end

  // decoded controls are registered so every output leaves a flop;
  // they lag the field by one clock, harmless for static setup bits
  logic d1_q, d2_q, d4_q, m0_q, m1_q, d1_d, d2_d, d4_d, m0_d, m1_d;

  always_comb begin
    // code 11 is reserved: no divider path is selected
    d1_d = (div_q == DIV_NONE);
    d2_d = (div_q == DIV_BY2);
    d4_d = (div_q == DIV_BY4);
    m0_d = eq_is_manual(eq0_q);
    m1_d = eq_is_manual(eq1_q);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      d1_q <= 1'b1;
      d2_q <= 1'b0;
      d4_q <= 1'b0;
      m0_q <= 1'b0;
      m1_q <= 1'b0;
    end else begin
      d1_q <= d1_d;
      d2_q <= d2_d;
      d4_q <= d4_d;
      m0_q <= m0_d;
      m1_q <= m1_d;
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = oe_q;
  assign lane_phy_powerdown = lane_pd_q;
  assign sync_request_buffer_powerdown = sync_pd_q;
  assign recovery_logic_run = run_q;
  assign half_rate_enable = half_q;
  assign oversample_div = div_q;
  assign div_by1 = d1_q;
  assign div_by2 = d2_q;
  assign div_by4 = d4_q;
  assign lane0_equalizer_setting = eq0_q;
  assign lane1_equalizer_setting = eq1_q;
  assign lane0_eq_manual = m0_q;
  assign lane1_eq_manual = m1_q;

endmodule : spcr_regs

`default_nettype wire

// ### verification/spcr_host.sv
// spcr_host: serial-port master standing in for configuration software.
// assumes mode 0 framing; drives on the falling clk edge.
`timescale 1ns/1ps
`default_nettype none
module spcr_host (
  input wire logic clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  output logic rd_done,
  output logic [7:0] rd_data,
  output logic oe_seen
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    rd_done = 1'b0;
    rd_data = 8'h00;
    oe_seen = 1'b0;
  end
  // four clk per sclk phase keeps the synchronised edges visible;
  // n below 24 raises chip select early to abort the frame
  task automatic xfer(input logic [23:0] w, input int n);
    @(negedge clk) spi_cs_n = 1'b0;
    oe_seen = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 23; i > 23 - n; i--) begin
      spi_sdi = w[i];
      repeat (4) @(negedge clk);
      spi_sclk = 1'b1;
      repeat (4) @(negedge clk);
      if (i < 8) rd_data[i] = spi_sdo;
      // the enable must stand through every data bit of a read
      if (i < 8) oe_seen = oe_seen & spi_sdo_oe;
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b1;
    // released line toggles so a stale bit never passes for data
    spi_sdi = ~spi_sdi;
    rd_done = w[23] && n == 24;
    repeat (6) @(negedge clk);
    rd_done = 1'b0;
  endtask : xfer
endmodule : spcr_host
`default_nettype wire

// ### verification/spcr_regs_chk.sv
// spcr_regs_chk: pin-level checks on the register bank.
// assumes it is bound to spcr_regs; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module spcr_regs_chk
  import spcr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic [7:0] lane_phy_powerdown,
  input wire logic sync_request_buffer_powerdown,
  input wire logic recovery_logic_run,
  input wire logic half_rate_enable,
  input wire logic [1:0] oversample_div,
  input wire logic div_by1,
  input wire logic div_by2,
  input wire logic div_by4,
  input wire logic [3:0] lane0_equalizer_setting,
  input wire logic [3:0] lane1_equalizer_setting,
  input wire logic lane0_eq_manual,
  input wire logic lane1_eq_manual
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a write lands well before chip select has idled eight cycles
  sequence idle8_s;
    spi_cs_n [*8];
  endsequence
  rst_ctl_a: assert property ($rose(arst_n) |-> recovery_logic_run
    && half_rate_enable && oversample_div == DIV_NONE && div_by1)
    else $error("control outputs wrong after reset");
  rst_fld_a: assert property ($rose(arst_n) |-> lane_phy_powerdown == 8'h00
    && !sync_request_buffer_powerdown && lane0_equalizer_setting == 4'h8
    && lane1_equalizer_setting == 4'h8) else $error("fields wrong after reset");
  div_dec_a: assert property (div_by1 == ($past(oversample_div) == DIV_NONE)
    && div_by2 == ($past(oversample_div) == DIV_BY2)
    && div_by4 == ($past(oversample_div) == DIV_BY4)) else $error("divider decode");
  eq_man_a: assert property (lane0_eq_manual ==
    ($past(lane0_equalizer_setting) == EQ_MANUAL) && lane1_eq_manual ==
    ($past(lane1_equalizer_setting) == EQ_MANUAL)) else $error("manual flag");
  pd_hold_a: assert property (idle8_s |-> $stable(lane_phy_powerdown)
    && $stable(sync_request_buffer_powerdown)) else $error("power down moved");
  ctl_hold_a: assert property (idle8_s |-> $stable(recovery_logic_run)
    && $stable({half_rate_enable, oversample_div})) else $error("control moved");
  eq_hold_a: assert property (idle8_s |-> $stable(lane0_equalizer_setting)
    && $stable(lane1_equalizer_setting)) else $error("equalizer moved");
  oe_idle_a: assert property (spi_cs_n [*6] |-> !spi_sdo_oe)
    else $error("sdo driven while idle");
  cover property ($rose(spi_sdo_oe));
  cover property ($rose(div_by4));
  cover property ($rose(lane1_eq_manual));
endmodule : spcr_regs_chk
bind spcr_regs spcr_regs_chk u_spcr_regs_chk (.clk(clk), .arst_n(arst_n),
  .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .lane_phy_powerdown(lane_phy_powerdown),
  .sync_request_buffer_powerdown(sync_request_buffer_powerdown),
  .recovery_logic_run(recovery_logic_run),
  .half_rate_enable(half_rate_enable),
  .oversample_div(oversample_div), .div_by1(div_by1), .div_by2(div_by2),
  .div_by4(div_by4), .lane0_equalizer_setting(lane0_equalizer_setting),
  .lane1_equalizer_setting(lane1_equalizer_setting),
  .lane0_eq_manual(lane0_eq_manual), .lane1_eq_manual(lane1_eq_manual));
`default_nettype wire

// ### verification/tb_spcr_regs.sv
// tb_spcr_regs: self-checking bench for the register bank.
// assumes spcr_host as serial master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_spcr_regs
  import spcr_pkg::*;
;
  logic clk, arst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
  logic oe_seen;
  logic sync_request_buffer_powerdown, recovery_logic_run, half_rate_enable;
  logic div_by1, div_by2, div_by4, lane0_eq_manual, lane1_eq_manual, rd_done;
  logic [7:0] lane_phy_powerdown, rd_data;
  logic [3:0] lane0_equalizer_setting, lane1_equalizer_setting;
  logic [1:0] oversample_div;
  logic [14:0] ad[6] = '{ADDR_LANE_PD, ADDR_MISC_PD, ADDR_RECOV_RST,
    ADDR_RECOV_MODE, ADDR_EQ_LANE01, 15'h0207};
  logic [7:0] rv[6] = '{RST_LANE_PD, RST_MISC_PD, RST_RECOV_RST,
    RST_RECOV_MODE, RST_EQ_LANE01, RD_UNMAPPED};
  // writable bits; the rest must read back as reset values
  logic [7:0] mk[6] = '{8'hFF, 8'h02, 8'h01, 8'h26, 8'hFF, 8'h00};
  // rate-consistent settings first, then reserved code 11 and all ones
  logic [11:0] dir[10] = '{12'h320, 12'h302, 12'h304, 12'h306, 12'h3FF,
    12'h400, 12'h4F1, 12'h200, 12'h1FF, 12'h5AA};
  logic [7:0] m[6];
  logic [33:0] q[$];
  logic [33:0] e;
  int n_errors = 0, checked = 0, seed = 75810, r;
  spcr_regs u_spcr_regs (.clk(clk), .arst_n(arst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .lane_phy_powerdown(lane_phy_powerdown),
    .sync_request_buffer_powerdown(sync_request_buffer_powerdown),
    .recovery_logic_run(recovery_logic_run),
    .half_rate_enable(half_rate_enable),
    .oversample_div(oversample_div), .div_by1(div_by1), .div_by2(div_by2),
    .div_by4(div_by4), .lane0_equalizer_setting(lane0_equalizer_setting),
    .lane1_equalizer_setting(lane1_equalizer_setting),
    .lane0_eq_manual(lane0_eq_manual), .lane1_eq_manual(lane1_eq_manual));
  spcr_host u_spcr_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .rd_done(rd_done), .rd_data(rd_data), .oe_seen(oe_seen));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [25:0] pv();
    logic [1:0] dv;
    dv = m[3][2:1];
    return {m[0], m[1][1], m[2][0], m[3][5], dv, dv == DIV_NONE,
      dv == DIV_BY2, dv == DIV_BY4, m[4], m[4][7:4] == EQ_MANUAL,
      m[4][3:0] == EQ_MANUAL};
  endfunction : pv
  task automatic chk(input string nm, input logic [33:0] s,
      input logic [33:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic acc(input int k, input logic rd, input logic [7:0] d,
      input int n);
    if (rd) q.push_back({m[k], pv()});
    u_spcr_host.xfer({rd, ad[k], d}, n);
    if (!rd && n == 24) m[k] = (m[k] & ~mk[k]) | (d & mk[k]);
  endtask : acc
  task automatic rd_all();
    for (int k = 0; k < 6; k++) acc(k, 1'b1, 8'h00, 24);
  endtask : rd_all
  task final_report();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial forever begin
    @(posedge rd_done);
    e = q.pop_front();
    chk("read data", rd_data, e[33:26]);
    chk("sdo enable", oe_seen, 1'b1);
    chk("outputs", {lane_phy_powerdown, sync_request_buffer_powerdown,
      recovery_logic_run, half_rate_enable, oversample_div, div_by1, div_by2,
      div_by4, lane1_equalizer_setting, lane0_equalizer_setting,
      lane1_eq_manual, lane0_eq_manual}, e[25:0]);
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    m = rv;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd_all();
    foreach (dir[i]) begin
      acc(dir[i][11:8], 1'b0, dir[i][7:0], 24);
      acc(dir[i][11:8], 1'b1, 8'h00, 24);
    end
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      acc(r[15:8] % 8'h06, 1'b0, r[7:0], 24);
      acc(r[15:8] % 8'h06, 1'b1, 8'h00, 24);
    end
    // aborted frames, one in the instruction and one in the data
    acc(0, 1'b0, 8'h5A, 20);
    acc(4, 1'b0, 8'h00, 12);
    acc(0, 1'b0, 8'hFF, 24);
    rd_all();
    arst_n = 1'b0;
    m = rv;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd_all();
    final_report();
  end
endmodule : tb_spcr_regs
`default_nettype wire
